// ===== dac_ctrl_pkg.sv
// package with register map, field layout and carrier types of the converter control block
package dac_ctrl_pkg;
   localparam int          NUM_CHAN      = 2;
   localparam int          CODE_W        = 8;
   localparam int          ADDR_W        = 16;
   localparam int          LADDER_STEPS  = 256;
   // control register at its printed offset; channel registers sit below it
   localparam logic [15:0] OFS_CONTROL   = 16'h00DC;
   localparam logic [15:0] OFS_CODE0     = 16'h00D8;
   localparam logic [15:0] OFS_CODE1     = 16'h00D9;
   localparam int          EN0_BIT       = 0;
   localparam int          EN1_BIT       = 1;
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [7:0]  CONTROL_MASK  = 8'h03;
   localparam logic [7:0]  CODE_RESET    = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] adr;
      logic [7:0]        dat;
      logic              we;
      logic              sel;
      logic              cyc;
      logic              stb;
   } wb_req_t;

   typedef struct packed {
      logic [7:0] code;
      logic       enable;
      logic       start;
   } chan_drive_t;
endpackage

// ===== dac_channel.sv
// one converter channel: holds the code, drives the ladder select and pin gate
`timescale 1ns/100ps
module dac_channel #(
   parameter int CODE_W = 8
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              load,
   input  wire logic [CODE_W-1:0] load_code,
   input  wire logic              enable,
   output logic [CODE_W-1:0]      code,
   output logic [CODE_W-1:0]      ladder_code,
   output logic                   out_enable,
   output logic                   conv_start
);
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic [CODE_W-1:0] ladder;
      logic              oe;
      logic              start;
   } chan_state_t;

   chan_state_t state_reg;
   chan_state_t state_next;

   always_comb begin
      state_next       = state_reg;
      state_next.start = 1'b0;
      if (load) begin
         state_next.code  = load_code;
         state_next.start = 1'b1;
      end
      // unsigned code picks tap n of the ladder, level = vref*n/256
      state_next.ladder = state_next.code;
      state_next.oe     = enable;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign code        = state_reg.code;
   assign ladder_code = state_reg.ladder;
   assign out_enable  = state_reg.oe;
   assign conv_start  = state_reg.start;
endmodule

// ===== dual_dac_control_regs.sv
// top: wishbone slave with control and code registers of the dual converter
`timescale 1ns/100ps
module dual_dac_control_regs #(
   parameter int NUM_CHAN = 2,
   parameter int CODE_W   = 8
) (
   input  wire logic                                  clk,
   input  wire logic                                  resetn,
   input  wire logic [15:0]                           wb_adr_i,
   input  wire logic [7:0]                            wb_dat_i,
   input  wire logic                                  wb_we_i,
   input  wire logic                                  wb_sel_i,
   input  wire logic                                  wb_cyc_i,
   input  wire logic                                  wb_stb_i,
   output logic [7:0]                                 wb_dat_o,
   output logic                                       wb_ack_o,
   output logic [NUM_CHAN-1:0][CODE_W-1:0]            ladder_code,
   output logic [NUM_CHAN-1:0]                        chan_output_enable,
   output logic [NUM_CHAN-1:0]                        conv_start
);
   typedef struct packed {
      logic [7:0] control;
      logic [7:0] rdata;
      logic       ack;
   } top_state_t;

   top_state_t                        state_reg;
   top_state_t                        state_next;
   dac_ctrl_pkg::wb_req_t             req;
   logic                              access;
   logic                              wr;
   logic [NUM_CHAN-1:0]               load;
   logic [NUM_CHAN-1:0][CODE_W-1:0]   code;

   assign req.adr = wb_adr_i;
   assign req.dat = wb_dat_i;
   assign req.we  = wb_we_i;
   assign req.sel = wb_sel_i;
   assign req.cyc = wb_cyc_i;
   assign req.stb = wb_stb_i;

   // one ack per request; ack drops the cycle after it was given
   assign access = req.cyc && req.stb && !state_reg.ack;
   assign wr     = access && req.we && req.sel;

   assign load[0] = wr && (req.adr == dac_ctrl_pkg::OFS_CODE0);
   assign load[1] = wr && (req.adr == dac_ctrl_pkg::OFS_CODE1);

   always_comb begin
      state_next       = state_reg;
      state_next.ack   = access;
      state_next.rdata = 8'h00;
      if (wr && req.adr == dac_ctrl_pkg::OFS_CONTROL) begin
         // upper bits are not stored and read as zero
         state_next.control = req.dat & dac_ctrl_pkg::CONTROL_MASK;
      end
      if (access && !req.we) begin
         unique case (req.adr)
            dac_ctrl_pkg::OFS_CONTROL:
               state_next.rdata = state_reg.control
                                  & dac_ctrl_pkg::CONTROL_MASK;
            dac_ctrl_pkg::OFS_CODE0:
               state_next.rdata = code[0];
            dac_ctrl_pkg::OFS_CODE1:
               state_next.rdata = code[1];
            default:
               state_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg.control <= dac_ctrl_pkg::CONTROL_RESET;
         state_reg.rdata   <= 8'h00;
         state_reg.ack     <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // channels are separate instances sharing nothing but the bus decode
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
         dac_channel #(
            .CODE_W (CODE_W)
         ) u_chan (
            .clk         (clk),
            .resetn      (resetn),
            .load        (load[gi]),
            .load_code   (req.dat[CODE_W-1:0]),
            .enable      (state_reg.control[gi]),
            .code        (code[gi]),
            .ladder_code (ladder_code[gi]),
            .out_enable  (chan_output_enable[gi]),
            .conv_start  (conv_start[gi])
         );
      end
   endgenerate

   assign wb_dat_o = state_reg.rdata;
   assign wb_ack_o = state_reg.ack;
endmodule

// ===== dual_dac_control_regs_assertions.sv
// bus timing and channel output checks of the dual converter block
`timescale 1ns/100ps
module dac_chk #(
   parameter int NUM_CHAN = 2,
   parameter int CODE_W   = 8
) (
   input wire logic                            clk,
   input wire logic                            resetn,
   input wire logic [15:0]                     wb_adr_i,
   input wire logic [7:0]                      wb_dat_i,
   input wire logic                            wb_we_i,
   input wire logic                            wb_sel_i,
   input wire logic                            wb_cyc_i,
   input wire logic                            wb_stb_i,
   input wire logic [7:0]                      wb_dat_o,
   input wire logic                            wb_ack_o,
   input wire logic [NUM_CHAN-1:0][CODE_W-1:0] ladder_code,
   input wire logic [NUM_CHAN-1:0]             chan_output_enable,
   input wire logic [NUM_CHAN-1:0]             conv_start
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   logic rq, rd, w0, w1, wc;
   assign rq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd = rq & ~wb_we_i;
   assign w0 = rq & wb_we_i & wb_sel_i & wb_adr_i == dac_ctrl_pkg::OFS_CODE0;
   assign w1 = rq & wb_we_i & wb_sel_i & wb_adr_i == dac_ctrl_pkg::OFS_CODE1;
   assign wc = rq & wb_we_i & wb_sel_i & wb_adr_i == dac_ctrl_pkg::OFS_CONTROL;
   property p_ack; rq |=> wb_ack_o ##1 !wb_ack_o; endproperty
   property p_ld0; w0 |=> ladder_code[0] == $past(wb_dat_i); endproperty
   property p_ld1; w1 |=> ladder_code[1] == $past(wb_dat_i); endproperty
   property p_ind; w0 |=> $stable(ladder_code[1]); endproperty
   property p_hold; !(w0 | w1) |=> $stable(ladder_code); endproperty
   property p_en; wc |=> ##1 chan_output_enable == $past(wb_dat_i[1:0], 2);
   endproperty
   property p_rsv; rd && wb_adr_i == dac_ctrl_pkg::OFS_CONTROL
      |=> wb_dat_o == {6'h00, chan_output_enable}; endproperty
   property p_rd0; rd && wb_adr_i == dac_ctrl_pkg::OFS_CODE0
      |=> wb_dat_o == ladder_code[0]; endproperty
   property p_cs; conv_start[0] |-> $past(w0); endproperty
   a_ack: assert property (p_ack) else $error("ack timing");
   a_ld0: assert property (p_ld0) else $error("code 0 load");
   a_ld1: assert property (p_ld1) else $error("code 1 load");
   a_ind: assert property (p_ind) else $error("channel coupling");
   a_hold: assert property (p_hold) else $error("code not held");
   a_en: assert property (p_en) else $error("enable mismatch");
   a_rsv: assert property (p_rsv) else $error("control read");
   a_rd0: assert property (p_rd0) else $error("code read");
   a_cs: assert property (p_cs) else $error("stray start");
   c_w0: cover property (w0);
   c_wc: cover property (wc);
   c_rd: cover property (rd);
endmodule
bind dual_dac_control_regs dac_chk #(.NUM_CHAN(NUM_CHAN), .CODE_W(CODE_W))
   i_chk (.*);

// ===== dual_dac_control_regs_bench.sv
// self-checking bench of the dual converter control registers
`timescale 1ns/100ps
module dual_dac_control_regs_bench;
   logic                  clk = 1'b0;
   logic                  resetn = 1'b0;
   dac_ctrl_pkg::wb_req_t r;
   logic [7:0]            dat_o, c, m[2], cv[5] = '{8'hFF, 8'h01, 8'h02, 8'hFC, 8'h00};
   logic                  ack;
   logic [1:0][7:0]       lad;
   logic [1:0]            en;
   logic [1:0]            cs;
   logic [7:0]            q[$];
   integer                errors = 0, n_tests = 0, seed = 32'h99877494;
   always #25 clk = ~clk;
   dual_dac_control_regs i_dut (.clk(clk), .resetn(resetn), .wb_adr_i(r.adr),
      .wb_dat_i(r.dat), .wb_we_i(r.we), .wb_sel_i(r.sel), .wb_cyc_i(r.cyc),
      .wb_stb_i(r.stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .ladder_code(lad),
      .chan_output_enable(en), .conv_start(cs));
   task automatic check(input logic [7:0] seen, exp, input string nm);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic [15:0] a, input logic [7:0] d,
                     input logic w, s);
      @(posedge clk);
      r <= '{a, d, w, s, 1'b1, 1'b1};
      // ack is seen as sampled at the edge; release only after that edge
      do @(posedge clk); while (ack !== 1'b1);
      r <= '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      q.push_back(e);
      wb(a, 8'h00, 1'b0, 1'b1);
   endtask
   always @(posedge clk)
      if (ack === 1'b1 && r.we === 1'b0 && q.size() > 0)
         check(dat_o, q.pop_front(), "read data");
   task automatic summarize;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      errors++;
      summarize();
   end
   initial begin
      r = '0;
      m = '{8'h00, 8'h00};
      repeat (3) @(posedge clk);
      for (int k = 0; k < 2; k++) begin
         resetn <= 1'b1;
         rd(dac_ctrl_pkg::OFS_CONTROL, 8'h00);
         for (int i = 0; i < 2; i++) rd(16'h00D8 + 16'(i), m[i]);
         repeat (3) for (int i = 0; i < 2; i++) begin
            c = 8'($random(seed));
            m[i] = c;
            wb(16'h00D8 + 16'(i), c, 1'b1, 1'b1);
            check({7'h00, cs[i]}, 8'h01, "start pulse");
            check(lad[i], c, "ladder");
            rd(16'h00D8 + 16'(i), c);
            rd(16'h00D9 - 16'(i), m[1-i]);
         end
         foreach (cv[j]) begin
            wb(dac_ctrl_pkg::OFS_CONTROL, cv[j], 1'b1, 1'b1);
            rd(dac_ctrl_pkg::OFS_CONTROL, cv[j] & 8'h03);
            check({6'h00, en}, cv[j] & 8'h03, "enable");
         end
         // unused channel: enable already cleared, code parked at zero
         wb(dac_ctrl_pkg::OFS_CODE1, 8'h00, 1'b1, 1'b1);
         m[1] = 8'h00;
         check(lad[1], 8'h00, "unused ladder");
         wb(dac_ctrl_pkg::OFS_CODE0, ~m[0], 1'b1, 1'b0);
         rd(dac_ctrl_pkg::OFS_CODE0, m[0]);
         wb(16'h00DD, 8'h5A, 1'b1, 1'b1);
         rd(16'h00DD, 8'h00);
         resetn <= 1'b0;
         m = '{8'h00, 8'h00};
         @(posedge clk);
      end
      summarize();
   end
endmodule
